// [shared/hbp_pkg.sv]
// constants, types and register map of the dual controller host bus port
// assumes one 25 MHz core clock and a synchronous active-low reset
package hbp_pkg;
	localparam int DATA_W = 16;
	localparam int FIFO_W = 17;
	localparam int FIFO_DEPTH = 16;
	localparam int CLK_MHZ = 25;
	// port codes on the two address lines
	localparam logic [1:0] PORT_HOST_DATA = 2'h0;
	localparam logic [1:0] PORT_HOST_CMD = 2'h1;
	localparam logic [1:0] PORT_DEV_DATA = 2'h2;
	localparam logic [1:0] PORT_DEV_CMD = 2'h3;
	// register indices, read form; write form adds the top bit
	localparam int IDX_WR_BIT = 7;
	localparam logic [7:0] IDX_BASE_MASK = 8'h7F;
	localparam logic [7:0] IDX_DMA_SETUP = 8'h21;
	localparam logic [7:0] IDX_XFER_COUNT = 8'h22;
	localparam logic [7:0] IDX_CHIP_ID = 8'h27;
	localparam logic [7:0] IDX_SCRATCH32 = 8'h28;
	localparam logic [7:0] IDX_BUFFER = 8'h40;
	localparam logic [7:0] IDX_RST = 8'h00;
	// dma_setup fields
	localparam int SETUP_EN_BIT = 0;
	localparam int SETUP_CNT_BIT = 1;
	localparam int SETUP_DIR_BIT = 2;
	localparam int SETUP_ACT_BIT = 3;
	localparam int SETUP_OVF_BIT = 4;
	localparam logic [2:0] SETUP_RST = 3'h0;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] BYTES_PER_WORD = 16'h0002;
	localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
	typedef enum logic [1:0] {DMA_IDLE, DMA_RUN, DMA_DONE} hbp_dma_t;
	// decoded access: who is addressed and how
	typedef struct packed {
		logic hit;
		logic side;
		logic cmd;
		logic dma;
	} hbp_sel_t;
endpackage : hbp_pkg

// [shared/hbp_stream_if.sv]
// valid/ready word stream between the port logic and its FIFO
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface hbp_stream_if #(parameter int W = 17) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : hbp_stream_if

// [src/hbp_fifo.sv]
// flip-flop FIFO with valid/ready on both sides
// assumes a single clock; full and empty come from an occupancy count
`timescale 1ns/1ps
module hbp_fifo #(
	parameter int W = 17,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// fill and drain sides
	hbp_stream_if.snk in_s,
	hbp_stream_if.src out_s
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	logic [W-1:0] mem_ff [DEPTH];
	logic [W-1:0] nxt_mem [DEPTH];
	logic [PW-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic push, pop;

	// honest flags: ready only while a slot is free
	assign in_s.ready = (cnt_ff != FULL_CNT);
	assign out_s.valid = (cnt_ff != '0);
	assign out_s.data = mem_ff[rptr_ff];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	// pointer and storage update
	always_comb begin
		nxt_mem = mem_ff;
		nxt_wptr = wptr_ff;
		nxt_rptr = rptr_ff;
		nxt_cnt = cnt_ff;
		if (push) begin
			nxt_mem[wptr_ff] = in_s.data;
			nxt_wptr = (wptr_ff == PW'(DEPTH - 1)) ? '0 : PW'(wptr_ff + 1'b1);
		end
		if (pop) begin
			nxt_rptr = (rptr_ff == PW'(DEPTH - 1)) ? '0 : PW'(rptr_ff + 1'b1);
		end
		if (push && !pop) begin
			nxt_cnt = CW'(cnt_ff + 1'b1);
		end else if (pop && !push) begin
			nxt_cnt = CW'(cnt_ff - 1'b1);
		end
	end

	// storage has no reset; only pointers and the occupancy count need a defined start
	always_ff @(posedge core_clk) begin
		mem_ff <= nxt_mem;
		if (!resetn) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
			cnt_ff <= nxt_cnt;
		end
	end
endmodule : hbp_fifo

// [src/hbp_host_port.sv]
// microprocessor bus port of a combined host and device controller
// assumes bus pins already synchronous to core_clk; buffer RAM sits behind buf_* ports
`timescale 1ns/1ps
module hbp_host_port import hbp_pkg::*; #(
	// identification word; value is arbitrary
	parameter logic [15:0] CHIP_ID = 16'h5A01
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// microprocessor bus
	input wire logic bus_cs_n,
	input wire logic [1:0] bus_addr,
	input wire logic bus_rd_n,
	input wire logic bus_wr_n,
	input wire logic [15:0] bus_data_in,
	output logic [15:0] bus_data_out,
	output logic bus_data_oe,
	// dma handshakes
	output logic host_side_dma_request,
	input wire logic host_side_dma_ack_n,
	output logic device_side_dma_request,
	input wire logic device_side_dma_ack_n,
	input wire logic end_of_transfer_n,
	// buffer RAM write stream
	output logic buf_wr_valid,
	input wire logic buf_wr_ready,
	output logic [15:0] buf_wr_data,
	output logic buf_wr_side,
	// buffer RAM read port
	input wire logic [15:0] buf_rd_data,
	output logic buf_rd_pop,
	output logic buf_rd_side
);
	logic [7:0] idx_ff [2];
	logic [7:0] nxt_idx [2];
	logic [2:0] setup_ff [2];
	logic [2:0] nxt_setup [2];
	logic [15:0] count_ff [2];
	logic [15:0] nxt_count [2];
	logic [15:0] bytes_ff [2];
	logic [15:0] nxt_bytes [2];
	hbp_dma_t dma_ff [2];
	hbp_dma_t nxt_dma [2];
	logic [1:0] ovf_ff, nxt_ovf;
	logic phase_ff, nxt_phase;
	logic [31:0] scratch_ff, nxt_scratch;
	logic [15:0] dout_ff, nxt_dout;
	logic rd_ff, nxt_rd, wr_ff, nxt_wr;
	logic acc_cs_n_ff, nxt_acc_cs_n;
	logic [1:0] acc_addr_ff, nxt_acc_addr;
	logic [1:0] acc_dack_n_ff, nxt_acc_dack_n;
	logic [15:0] acc_data_ff, nxt_acc_data;
	logic [7:0] acc_index;
	logic [1:0] dack_n, eot_ext, req;
	logic wr_end, rd_end, push_ready;
	hbp_sel_t cur, lat;

	hbp_stream_if #(.W(FIFO_W)) push_s ();
	hbp_stream_if #(.W(FIFO_W)) pop_s ();

	// one decoder for the live pins and for the latched access
	function automatic hbp_sel_t decode_port(input logic cs_n, input logic [1:0] addr, input logic [1:0] dk_n);
		hbp_sel_t r;
		r = '0;
		if (!dk_n[0]) begin
			r.hit = 1'b1;
			r.dma = 1'b1;
		end else if (!dk_n[1]) begin
			r.hit = 1'b1;
			r.side = 1'b1;
			r.dma = 1'b1;
		end else if (!cs_n) begin
			r.hit = 1'b1;
			r.side = addr[1];
			r.cmd = addr[0];
		end
		return r;
	endfunction : decode_port

	// buffer words allowed: dma while running, programmed_io below byte count
	function automatic logic buf_ok(input logic side, input logic dma);
		return dma ? (dma_ff[side] == DMA_RUN) : (bytes_ff[side] < count_ff[side]);
	endfunction : buf_ok

	// word seen on a data-port read; write-form indices read as zero
	function automatic logic [15:0] read_word(input logic side, input logic dma);
		logic [7:0] idx;
		logic [15:0] r;
		idx = dma ? IDX_BUFFER : idx_ff[side];
		r = 16'h0000;
		if (!idx[IDX_WR_BIT]) begin
			case (idx)
				IDX_DMA_SETUP: begin
					r = {11'h000, ovf_ff[side], dma_ff[side] == DMA_RUN, setup_ff[side]};
				end
				IDX_XFER_COUNT: begin
					r = count_ff[side];
				end
				IDX_CHIP_ID: begin
					r = side ? 16'h0000 : CHIP_ID;
				end
				IDX_SCRATCH32: begin
					r = side ? 16'h0000 : (phase_ff ? scratch_ff[31:16] : scratch_ff[15:0]);
				end
				IDX_BUFFER: begin
					r = buf_ok(side, dma) ? buf_rd_data : 16'h0000;
				end
				default: begin
					r = 16'h0000;
				end
			endcase
		end
		return r;
	endfunction : read_word

	assign dack_n = {device_side_dma_ack_n, host_side_dma_ack_n};
	assign eot_ext = {2{!end_of_transfer_n}} & ~dack_n;
	assign wr_end = !wr_ff && bus_wr_n;
	assign rd_end = !rd_ff && bus_rd_n;
	assign acc_index = acc_data_ff[7:0];
	assign cur = decode_port(bus_cs_n, bus_addr, dack_n);
	assign lat = decode_port(acc_cs_n_ff, acc_addr_ff, acc_dack_n_ff);
	assign push_ready = push_s.ready;

	// drive only during a data-port or acknowledged read
	assign bus_data_oe = !bus_rd_n && cur.hit && !cur.cmd;
	assign bus_data_out = dout_ff;
	assign buf_rd_side = cur.side;

	// request holds while the channel runs; a full FIFO stalls a write burst
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			req[s] = (dma_ff[s] == DMA_RUN) && (!setup_ff[s][SETUP_DIR_BIT] || push_ready);
		end
	end
	assign host_side_dma_request = req[0];
	assign device_side_dma_request = req[1];

	// buffer write stream goes through the FIFO
	assign buf_wr_valid = pop_s.valid;
	assign buf_wr_side = pop_s.data[16];
	assign buf_wr_data = pop_s.data[15:0];
	assign pop_s.ready = buf_wr_ready;

	hbp_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.resetn(resetn),
		.in_s(push_s.snk),
		.out_s(pop_s.src)
	);

	// access tracking: latch select and data while a strobe is low
	always_comb begin
		nxt_rd = bus_rd_n;
		nxt_wr = bus_wr_n;
		nxt_acc_cs_n = acc_cs_n_ff;
		nxt_acc_addr = acc_addr_ff;
		nxt_acc_dack_n = acc_dack_n_ff;
		nxt_acc_data = acc_data_ff;
		nxt_dout = dout_ff;
		if (!bus_rd_n || !bus_wr_n) begin
			nxt_acc_cs_n = bus_cs_n;
			nxt_acc_addr = bus_addr;
			nxt_acc_dack_n = dack_n;
			nxt_acc_data = bus_data_in;
		end
		if (!bus_rd_n && cur.hit && !cur.cmd) begin
			nxt_dout = read_word(cur.side, cur.dma);
		end
	end

	// register file, index, counters and channel state
	always_comb begin
		nxt_idx = idx_ff;
		nxt_setup = setup_ff;
		nxt_count = count_ff;
		nxt_bytes = bytes_ff;
		nxt_dma = dma_ff;
		nxt_ovf = ovf_ff;
		nxt_phase = phase_ff;
		nxt_scratch = scratch_ff;
		push_s.valid = 1'b0;
		push_s.data = '0;
		buf_rd_pop = 1'b0;
		// channel state: either end of transfer stops a run
		for (int s = 0; s < 2; s++) begin
			case (dma_ff[s])
				DMA_IDLE: begin
					nxt_dma[s] = DMA_IDLE;
				end
				DMA_RUN: begin
					if (eot_ext[s]) begin
						nxt_dma[s] = DMA_DONE;
					end else if (setup_ff[s][SETUP_CNT_BIT] && bytes_ff[s] >= count_ff[s]) begin
						nxt_dma[s] = DMA_DONE;
					end else begin
						nxt_dma[s] = DMA_RUN;
					end
				end
				DMA_DONE: begin
					nxt_dma[s] = DMA_DONE;
				end
				default: begin
					nxt_dma[s] = DMA_IDLE;
				end
			endcase
		end
		if (wr_end && lat.hit && lat.cmd) begin
			// command phase: keep the index, restart multi-phase access
			nxt_idx[lat.side] = acc_index;
			nxt_phase = 1'b0;
			if ((acc_index & IDX_BASE_MASK) == IDX_BUFFER) begin
				nxt_bytes[lat.side] = COUNT_RST;
			end
		end else if (wr_end && lat.hit) begin
			case (lat.dma ? (IDX_BUFFER | 8'h80) : idx_ff[lat.side])
				IDX_DMA_SETUP | 8'h80: begin
					nxt_setup[lat.side] = acc_data_ff[2:0];
					nxt_ovf[lat.side] = 1'b0;
					nxt_bytes[lat.side] = COUNT_RST;
					nxt_dma[lat.side] = acc_data_ff[SETUP_EN_BIT] ? DMA_RUN : DMA_IDLE;
				end
				IDX_XFER_COUNT | 8'h80: begin
					nxt_count[lat.side] = acc_data_ff;
				end
				IDX_SCRATCH32 | 8'h80: begin
					if (!lat.side) begin
						// low half lands first, high half second
						if (phase_ff) begin
							nxt_scratch[31:16] = acc_data_ff;
						end else begin
							nxt_scratch[15:0] = acc_data_ff;
						end
						nxt_phase = !phase_ff;
					end
				end
				IDX_BUFFER | 8'h80: begin
					if (buf_ok(lat.side, lat.dma)) begin
						push_s.valid = 1'b1;
						push_s.data = {lat.side, acc_data_ff};
						if (push_ready) begin
							nxt_bytes[lat.side] = 16'(bytes_ff[lat.side] + BYTES_PER_WORD);
						end else begin
							// no wait pin, so a full FIFO drops the word and flags it
							nxt_ovf[lat.side] = 1'b1;
						end
					end
				end
				default: begin
					nxt_phase = phase_ff;
				end
			endcase
		end else if (rd_end && lat.hit && !lat.cmd) begin
			case (lat.dma ? IDX_BUFFER : idx_ff[lat.side])
				IDX_SCRATCH32: begin
					nxt_phase = lat.side ? phase_ff : !phase_ff;
				end
				IDX_BUFFER: begin
					if (buf_ok(lat.side, lat.dma)) begin
						buf_rd_pop = 1'b1;
						nxt_bytes[lat.side] = 16'(bytes_ff[lat.side] + BYTES_PER_WORD);
					end
				end
				default: begin
					nxt_phase = phase_ff;
				end
			endcase
		end
	end

	// state registers
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			idx_ff <= '{IDX_RST, IDX_RST};
			setup_ff <= '{SETUP_RST, SETUP_RST};
			count_ff <= '{COUNT_RST, COUNT_RST};
			bytes_ff <= '{COUNT_RST, COUNT_RST};
			dma_ff <= '{DMA_IDLE, DMA_IDLE};
			ovf_ff <= 2'h0;
			phase_ff <= 1'b0;
			scratch_ff <= SCRATCH_RST;
			dout_ff <= 16'h0000;
			rd_ff <= 1'b1;
			wr_ff <= 1'b1;
			acc_cs_n_ff <= 1'b1;
			acc_addr_ff <= 2'h0;
			acc_dack_n_ff <= 2'h3;
			acc_data_ff <= 16'h0000;
		end else begin
			idx_ff <= nxt_idx;
			setup_ff <= nxt_setup;
			count_ff <= nxt_count;
			bytes_ff <= nxt_bytes;
			dma_ff <= nxt_dma;
			ovf_ff <= nxt_ovf;
			phase_ff <= nxt_phase;
			scratch_ff <= nxt_scratch;
			dout_ff <= nxt_dout;
			rd_ff <= nxt_rd;
			wr_ff <= nxt_wr;
			acc_cs_n_ff <= nxt_acc_cs_n;
			acc_addr_ff <= nxt_acc_addr;
			acc_dack_n_ff <= nxt_acc_dack_n;
			acc_data_ff <= nxt_acc_data;
		end
	end

	// checks on decode, index use and channel behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	cmd_port_silent_a: assert property (
		(!bus_rd_n && !bus_cs_n && bus_addr[0] && host_side_dma_ack_n && device_side_dma_ack_n) |-> !bus_data_oe
	) else $error("command port drove the data bus");

	index_capture_a: assert property (
		(wr_end && lat.hit && lat.cmd && !lat.side) |=> (idx_ff[0] == $past(acc_index))
	) else $error("host index not taken from command write");

	chip_id_read_a: assert property (
		(!bus_rd_n && !bus_cs_n && bus_addr == PORT_HOST_DATA && host_side_dma_ack_n
			&& device_side_dma_ack_n && idx_ff[0] == IDX_CHIP_ID) |=> (bus_data_out == CHIP_ID)
	) else $error("chip identification not returned");

	low_half_first_a: assert property (
		(wr_end && lat.hit && lat.cmd) |=> !phase_ff
	) else $error("32-bit access did not restart at low half");

	ext_end_stop_a: assert property (
		(dma_ff[0] == DMA_RUN && !end_of_transfer_n && !host_side_dma_ack_n) |=> (dma_ff[0] == DMA_DONE)
	) else $error("external end of transfer ignored");

	count_end_stop_a: assert property (
		(dma_ff[0] == DMA_RUN && setup_ff[0][SETUP_CNT_BIT] && bytes_ff[0] >= count_ff[0])
			|=> (dma_ff[0] != DMA_RUN) && !host_side_dma_request
	) else $error("internal end of transfer missed");

	request_idle_a: assert property (
		(dma_ff[1] != DMA_RUN) |-> !device_side_dma_request
	) else $error("device side request outside a run");

	// one cycle only: an end of transfer may legally arrive on the very next edge
	run_repeats_a: assert property (
		(dma_ff[0] == DMA_RUN && end_of_transfer_n && !setup_ff[0][SETUP_CNT_BIT] && !(wr_end && lat.hit))
			|=> (dma_ff[0] == DMA_RUN)
	) else $error("dma run ended without end of transfer");

	pio_limit_a: assert property (
		(wr_end && lat.hit && !lat.cmd && !lat.dma && idx_ff[0] == (IDX_BUFFER | 8'h80) && !lat.side
			&& bytes_ff[0] >= count_ff[0]) |-> !push_s.valid
	) else $error("buffer word accepted past byte count");
endmodule : hbp_host_port

// [test/hbp_buf_model.sv]
// buffer RAM stand-in behind the port: takes written words, hands out read words
// assumes it shares core_clk with the port; stall and slow come from the bench
`timescale 1ns/1ps
module hbp_buf_model (
	// clock
	input wire logic core_clk,
	// pacing from the bench
	input wire logic stall,
	input wire logic slow,
	// write stream
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [15:0] wr_data,
	input wire logic wr_side,
	// read port
	output logic [15:0] rd_data,
	input wire logic rd_pop,
	input wire logic rd_side
);
	logic [16:0] q [$];
	logic [7:0] cnt [0:1] = '{8'h00, 8'h00};
	logic coin = 1'b1;
	// slow mode accepts on a random half of the cycles, so the FIFO backs up
	assign wr_ready = ~stall & (~slow | coin);
	// each read word carries its side and position, so a skipped pop shows up
	assign rd_data = {rd_side ? 8'hD0 : 8'hA0, cnt[rd_side]};
	// capture accepted words, advance on pops
	always @(posedge core_clk) begin
		if (wr_valid && wr_ready) begin
			q.push_back({wr_side, wr_data});
		end
		if (rd_pop) begin
			cnt[rd_side] <= cnt[rd_side] + 8'h01;
		end
		coin <= 1'($urandom);
	end
endmodule : hbp_buf_model

// [test/tb_top.sv]
// self-checking bench for the host bus port, acting as processor and dma master
// assumes hbp_pkg, the port, its FIFO and the buffer model are compiled first
`timescale 1ns/1ps
module tb_top import hbp_pkg::*; ();
	localparam logic [15:0] ID = 16'h3C5A; // arbitrary identification value
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [15:0] din = 16'h0000;
	logic ack1_n = 1'b1;
	logic ack2_n = 1'b1;
	logic eot_n = 1'b1;
	logic stall = 1'b0;
	logic slow = 1'b0;
	logic [15:0] dout, wdat, rdat, got, want;
	logic oe, req1, req2, wval, wrdy, wside, pop, rside, oe_seen;
	logic [16:0] eq [$];
	int mismatches = 0;
	int tests_run = 0;
	hbp_host_port #(.CHIP_ID(ID)) dut (.core_clk(core_clk), .resetn(resetn), .bus_cs_n(cs_n),
		.bus_addr(addr), .bus_rd_n(rd_n), .bus_wr_n(wr_n), .bus_data_in(din), .bus_data_out(dout),
		.bus_data_oe(oe), .host_side_dma_request(req1), .host_side_dma_ack_n(ack1_n),
		.device_side_dma_request(req2), .device_side_dma_ack_n(ack2_n), .end_of_transfer_n(eot_n),
		.buf_wr_valid(wval), .buf_wr_ready(wrdy), .buf_wr_data(wdat), .buf_wr_side(wside),
		.buf_rd_data(rdat), .buf_rd_pop(pop), .buf_rd_side(rside));
	hbp_buf_model bm (.core_clk(core_clk), .stall(stall), .slow(slow), .wr_valid(wval),
		.wr_ready(wrdy), .wr_data(wdat), .wr_side(wside), .rd_data(rdat), .rd_pop(pop),
		.rd_side(rside));
	always #20 core_clk = ~core_clk;
	// the one exit of the run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [16:0] g, input logic [16:0] e, input string m);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	// bus write: strobe low one cycle, cs held through the edge that acts
	task automatic bwr(input logic [1:0] a, input logic [15:0] d);
		@(negedge core_clk);
		cs_n = 1'b0;
		addr = a;
		din = d;
		wr_n = 1'b0;
		@(negedge core_clk);
		wr_n = 1'b1;
		@(negedge core_clk);
		cs_n = 1'b1;
		din = ~d;
	endtask : bwr
	// bus read: data is settled on the second cycle of the low strobe
	task automatic brd(input logic [1:0] a, output logic [15:0] d);
		@(negedge core_clk);
		cs_n = 1'b0;
		addr = a;
		rd_n = 1'b0;
		@(negedge core_clk);
		@(negedge core_clk);
		d = dout;
		oe_seen = oe;
		rd_n = 1'b1;
		@(negedge core_clk);
		cs_n = 1'b1;
	endtask : brd
	task automatic rreg(input logic s, input logic [7:0] i, output logic [15:0] d);
		bwr({s, 1'b1}, {8'h00, i});
		brd({s, 1'b0}, d);
	endtask : rreg
	task automatic wreg(input logic s, input logic [7:0] i, input logic [15:0] d);
		bwr({s, 1'b1}, {8'h00, i | 8'h80});
		bwr({s, 1'b0}, d);
	endtask : wreg
	// dma words as the external master; the first keep of them are expected
	task automatic dsend(input logic s, input int cnt, input int keep);
		logic [15:0] d;
		for (int k = 0; k < cnt; k++) begin
			d = 16'($urandom);
			@(negedge core_clk);
			ack1_n = s;
			ack2_n = ~s;
			din = d;
			wr_n = 1'b0;
			@(negedge core_clk);
			wr_n = 1'b1;
			@(negedge core_clk);
			ack1_n = 1'b1;
			ack2_n = 1'b1;
			din = ~d;
			if (k < keep) begin
				eq.push_back({s, d});
			end
		end
	endtask : dsend
	task automatic deot(input logic s);
		@(negedge core_clk);
		ack1_n = s;
		ack2_n = ~s;
		eot_n = 1'b0;
		@(negedge core_clk);
		ack1_n = 1'b1;
		ack2_n = 1'b1;
		eot_n = 1'b1;
	endtask : deot
	task automatic wreq(input logic s, input logic e);
		int k;
		k = 0;
		while (((s ? req2 : req1) !== e) && k < 60) begin
			@(negedge core_clk);
			k++;
		end
		chk(17'(k < 60), 17'h00001, "request wait");
		if (k >= 60) begin
			tally_and_finish();
		end
	endtask : wreq
	// wait for the buffer model to hold every expected word, then compare in order
	task automatic drain();
		int k;
		k = 0;
		while (bm.q.size() < eq.size() && k < 200) begin
			@(negedge core_clk);
			k++;
		end
		if (k >= 200) begin
			chk(17'(bm.q.size()), 17'(eq.size()), "drain timeout");
			tally_and_finish();
		end
		while (eq.size() > 0) begin
			chk(bm.q.pop_front(), eq.pop_front(), "buffer word");
		end
		chk(17'(bm.q.size()), 17'h00000, "extra words");
	endtask : drain
	initial begin
		void'($urandom(32'hDE369F23));
		repeat (16) @(negedge core_clk);
		resetn = 1'b1;
		@(negedge core_clk);
		// identification word, kept index, command port not driven
		rreg(1'b0, IDX_CHIP_ID, got);
		chk(got, ID, "chip id");
		chk(oe_seen, 1'b1, "data port oe");
		brd(PORT_HOST_DATA, got);
		chk(got, ID, "id again");
		brd(PORT_HOST_CMD, got);
		chk(oe_seen, 1'b0, "cmd port oe");
		$display("test identification done");
		// count registers of both sides, reset value and write-form read refused
		for (int s = 0; s < 2; s++) begin
			rreg(s[0], IDX_XFER_COUNT, got);
			chk(got, COUNT_RST, "count reset");
			rreg(s[0], IDX_DMA_SETUP, got);
			chk(got, 16'h0000, "setup reset");
			want = 16'($urandom);
			wreg(s[0], IDX_XFER_COUNT, want);
			rreg(s[0], IDX_XFER_COUNT | 8'h80, got);
			chk(got, 16'h0000, "write form read");
			rreg(s[0], IDX_XFER_COUNT, got);
			chk(got, want, "count");
		end
		$display("test counters done");
		// 32-bit register, low half first
		eq.push_back(17'($urandom));
		eq.push_back(17'($urandom));
		bwr(PORT_HOST_CMD, {8'h00, IDX_SCRATCH32 | 8'h80});
		bwr(PORT_HOST_DATA, eq[0][15:0]);
		bwr(PORT_HOST_DATA, eq[1][15:0]);
		bwr(PORT_HOST_CMD, {8'h00, IDX_SCRATCH32});
		brd(PORT_HOST_DATA, got);
		chk(got, eq[0][15:0], "low half");
		brd(PORT_HOST_DATA, got);
		chk(got, eq[1][15:0], "high half");
		eq.delete();
		$display("test wide register done");
		// buffer reads and writes by programmed io, stopping at the byte count
		for (int s = 0; s < 2; s++) begin
			wreg(s[0], IDX_XFER_COUNT, 16'h0004);
			bwr({s[0], 1'b1}, {8'h00, IDX_BUFFER});
			for (int k = 0; k < 3; k++) begin
				brd({s[0], 1'b0}, got);
				chk(got, k < 2 ? {s[0] ? 8'hD0 : 8'hA0, 8'(k)} : 16'h0000, "buffer read");
			end
			bwr({s[0], 1'b1}, {8'h00, IDX_BUFFER | 8'h80});
			for (int k = 0; k < 3; k++) begin
				got = 16'($urandom);
				bwr({s[0], 1'b0}, got);
				if (k < 2) begin
					eq.push_back({s[0], got});
				end
			end
			drain();
		end
		$display("test buffer io done");
		// host dma, internal counter ends it after four words, slow buffer
		slow = 1'b1;
		wreg(1'b0, IDX_XFER_COUNT, 16'h0008);
		wreg(1'b0, IDX_DMA_SETUP, 16'h0007);
		wreq(1'b0, 1'b1);
		dsend(1'b0, 4, 4);
		wreq(1'b0, 1'b0);
		rreg(1'b0, IDX_DMA_SETUP, got);
		chk(got, 16'h0007, "setup after count");
		drain();
		// device dma keeps going until the external end
		wreg(1'b1, IDX_DMA_SETUP, 16'h0005);
		wreq(1'b1, 1'b1);
		dsend(1'b1, 3, 3);
		chk(req2, 1'b1, "still running");
		deot(1'b1);
		wreq(1'b1, 1'b0);
		drain();
		$display("test dma done");
		// buffer full: extra words dropped and flagged, then drained
		slow = 1'b0;
		stall = 1'b1;
		wreg(1'b0, IDX_DMA_SETUP, 16'h0005);
		wreq(1'b0, 1'b1);
		dsend(1'b0, FIFO_DEPTH + 2, FIFO_DEPTH);
		chk(wval, 1'b1, "fifo holding");
		rreg(1'b0, IDX_DMA_SETUP, got);
		chk(got, 16'h001D, "overflow flag");
		deot(1'b0);
		wreq(1'b0, 1'b0);
		stall = 1'b0;
		drain();
		$display("test overflow done");
		tally_and_finish();
	end
endmodule : tb_top
